// ==== design/aac_top.sv ====
// Purpose: alarm handling unit: alarm states, clearing, buzzer, events, zoom
// Assumes: all inputs synchronous to mclk_i; keys are high while pressed
// Notes: events leave one per cycle; bursts wait in per-alarm ON and OFF pending bits
// ****************************************
// How it works
// - magnify enabled: up key in overview enters zoomed mode
// - zoomed: up, down, left, right move the selected alarm box
// - back key while zoomed returns to normal overview
// - clear-all input acknowledges and clears every clearable alarm
// - buzzer output asserts whenever any alarm becomes active
// - buzzer is a plain output meant to drive a relay
// - back key or mute input silences the buzzer
// - latched source stays set until back key pressed
// - source rise gives ON event, fall gives OFF event
// - per-alarm masks pick ON, OFF or both; others dropped
// - active source ignores clears unless clear-active option set
// - dropped unacknowledged alarm waits for clear before inactive
// - cleared while active: acknowledged, inactive once source drops
// ****************************************
module aac_top
    import aac_pkg::*;
#(
    parameter int N = AAC_NUM_ALARMS,
    parameter int COLS = AAC_COLS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // alarm sources and per-alarm settings
    input wire logic [N-1:0] src_i,
    input wire logic [N-1:0] latch_en_i,
    input wire logic [N-1:0] evt_on_sel_i,
    input wire logic [N-1:0] evt_off_sel_i,
    // global options
    input wire logic clr_act_en_i,
    input wire logic zoom_en_i,
    // front-panel keys
    input wire logic key_up_i,
    input wire logic key_down_i,
    input wire logic key_left_i,
    input wire logic key_right_i,
    input wire logic key_back_i,
    input wire logic fbtn_clear_i,
    // logic inputs
    input wire logic clear_all_i,
    input wire logic buzz_mute_i,
    // alarm status
    output logic [2*N-1:0] state_o,
    output logic buzzer_o,
    // navigation
    output logic zoom_o,
    output logic [AAC_IDX_W-1:0] sel_o,
    // event stream
    output logic evt_valid_o,
    output logic [AAC_IDX_W-1:0] evt_idx_o,
    output logic evt_on_o
);
    // ****************************************
    // key edges
    // ****************************************
    logic [6:0] keys;
    logic [6:0] keys_q_ff;
    logic [6:0] key_pr;
    logic up_pr;
    logic down_pr;
    logic left_pr;
    logic right_pr;
    logic back_pr;
    logic fbtn_pr;
    logic mute_pr;

    assign keys = {buzz_mute_i, fbtn_clear_i, key_back_i, key_right_i, key_left_i, key_down_i, key_up_i};
    assign key_pr = keys & ~keys_q_ff;
    assign up_pr = key_pr[0];
    assign down_pr = key_pr[1];
    assign left_pr = key_pr[2];
    assign right_pr = key_pr[3];
    assign back_pr = key_pr[4];
    // a held function button clears once; press and release is expected
    assign fbtn_pr = key_pr[5];
    assign mute_pr = key_pr[6];

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            keys_q_ff <= '0;
        end else begin
            keys_q_ff <= keys;
        end
    end

    // ****************************************
    // latched sources
    // ****************************************
    logic [N-1:0] latch_ff;
    logic [N-1:0] nxt_latch;
    logic [N-1:0] eff_src;

    // set wins over the back-key release of the latch
    assign nxt_latch = latch_en_i & (src_i | (latch_ff & ~{N{back_pr}}));
    assign eff_src = src_i | (latch_ff & latch_en_i);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            latch_ff <= '0;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // ****************************************
    // alarm cells
    // ****************************************
    logic clr_req;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    // clear-all acts as a level: every cycle it is high is a clear
    assign clr_req = fbtn_pr | clear_all_i;

    for (genvar i = 0; i < N; i++) begin : g_cell
        aac_state_t cell_st;
        aac_alarm_cell u_cell (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .src_i(eff_src[i]),
            .clear_i(clr_req),
            .clr_act_en_i(clr_act_en_i),
            .state_o(cell_st),
            .rise_o(rise[i]),
            .fall_o(fall[i])
        );
        assign state_o[2*i+:2] = cell_st;
    end

    // ****************************************
    // buzzer
    // ****************************************
    logic any_rise;
    logic buzz_ff;
    logic nxt_buzz;

    assign any_rise = |rise;
    // activation beats a silence in the same cycle so no alarm is missed
    assign nxt_buzz = any_rise | (buzz_ff & ~(back_pr | mute_pr));
    // relay mapping is outside; this is a plain level for one output contact
    assign buzzer_o = buzz_ff;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            buzz_ff <= AAC_BUZZ_RST;
        end else begin
            buzz_ff <= nxt_buzz;
        end
    end

    // ****************************************
    // events
    // ****************************************
    logic [N-1:0] pend_on_ff;
    logic [N-1:0] pend_off_ff;
    logic [N-1:0] nxt_pend_on;
    logic [N-1:0] nxt_pend_off;
    logic [2*N-1:0] pend_all;
    logic [2*N-1:0] gnt_vec;
    logic pick_valid;
    logic [AAC_EVT_W-1:0] pick_idx;
    logic evt_valid_ff;
    logic [AAC_IDX_W-1:0] evt_idx_ff;
    logic evt_on_ff;

    assign pend_all = {pend_off_ff, pend_on_ff};
    assign gnt_vec = pick_valid ? ({{(2*N-1){1'b0}}, 1'b1} << pick_idx) : '0;
    // a new edge on a granted alarm stays pending
    assign nxt_pend_on = (pend_on_ff & ~gnt_vec[N-1:0]) | (rise & evt_on_sel_i);
    assign nxt_pend_off = (pend_off_ff & ~gnt_vec[2*N-1:N]) | (fall & evt_off_sel_i);
    assign evt_valid_o = evt_valid_ff;
    assign evt_idx_o = evt_idx_ff;
    assign evt_on_o = evt_on_ff;

    aac_evt_pick #(
        .W(2 * N),
        .IW(AAC_EVT_W)
    ) u_pick (
        .req_i(pend_all),
        .valid_o(pick_valid),
        .idx_o(pick_idx)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pend_on_ff <= '0;
            pend_off_ff <= '0;
            evt_valid_ff <= 1'b0;
            evt_idx_ff <= '0;
            evt_on_ff <= 1'b0;
        end else begin
            pend_on_ff <= nxt_pend_on;
            pend_off_ff <= nxt_pend_off;
            evt_valid_ff <= pick_valid;
            evt_idx_ff <= pick_idx[AAC_IDX_W-1:0];
            evt_on_ff <= ~pick_idx[AAC_EVT_W-1];
        end
    end

    // ****************************************
    // zoom navigation
    // ****************************************
    localparam logic [AAC_IDX_W-1:0] ROW_STEP = AAC_IDX_W'(COLS);
    localparam logic [AAC_IDX_W-1:0] LAST_IDX = AAC_IDX_W'(N - 1);
    logic zoom_ff;
    logic nxt_zoom;
    logic [AAC_IDX_W-1:0] sel_ff;
    logic [AAC_IDX_W-1:0] nxt_sel;
    logic can_up;
    logic can_down;
    logic can_left;
    logic can_right;

    assign can_up = sel_ff >= ROW_STEP;
    assign can_down = sel_ff <= LAST_IDX - ROW_STEP;
    assign can_left = sel_ff != '0;
    assign can_right = sel_ff != LAST_IDX;

    always_comb begin
        nxt_zoom = zoom_ff;
        nxt_sel = sel_ff;
        if (!zoom_ff) begin
            if (up_pr && zoom_en_i) nxt_zoom = 1'b1;
        end else if (back_pr) begin
            nxt_zoom = 1'b0;
        end else if (up_pr) begin
            if (can_up) nxt_sel = sel_ff - ROW_STEP;
        end else if (down_pr) begin
            if (can_down) nxt_sel = sel_ff + ROW_STEP;
        end else if (left_pr) begin
            if (can_left) nxt_sel = sel_ff - 7'h01;
        end else if (right_pr) begin
            if (can_right) nxt_sel = sel_ff + 7'h01;
        end
    end

    assign zoom_o = zoom_ff;
    assign sel_o = sel_ff;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            zoom_ff <= AAC_ZOOM_RST;
            sel_ff <= AAC_SEL_RST;
        end else begin
            zoom_ff <= nxt_zoom;
            sel_ff <= nxt_sel;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_buzz_on_rise: assert property (@(posedge mclk_i) disable iff (rst_i)
        any_rise |=> buzzer_o)
        else $error("buzzer missed an activation");
    a_buzz_silence: assert property (@(posedge mclk_i) disable iff (rst_i)
        (back_pr || mute_pr) && !any_rise |=> !buzzer_o)
        else $error("buzzer not silenced");
    a_buzz_stays_off: assert property (@(posedge mclk_i) disable iff (rst_i)
        !buzzer_o && !any_rise |=> !buzzer_o)
        else $error("buzzer rose without activation");
    a_zoom_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
        !zoom_o && up_pr |=> zoom_o == $past(zoom_en_i))
        else $error("zoom entry wrong");
    a_zoom_exit: assert property (@(posedge mclk_i) disable iff (rst_i)
        zoom_o && back_pr |=> !zoom_o && $stable(sel_o))
        else $error("zoom did not exit on back");
    a_nav_right: assert property (@(posedge mclk_i) disable iff (rst_i)
        zoom_o && key_pr[4:0] == 5'h08 && sel_o != LAST_IDX |=> sel_o == $past(sel_o) + 7'h01)
        else $error("right key did not step");
    a_nav_down: assert property (@(posedge mclk_i) disable iff (rst_i)
        zoom_o && key_pr[4:0] == 5'h02 && can_down |=> sel_o == $past(sel_o) + ROW_STEP)
        else $error("down key did not step a row");
    a_latch_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        !back_pr |=> ((($past(latch_ff) & $past(latch_en_i)) & ~latch_ff) == '0))
        else $error("latched source released without back");
    a_evt_drain: assert property (@(posedge mclk_i) disable iff (rst_i)
        (|pend_all) |=> evt_valid_o && (evt_on_o == $past(|pend_on_ff)))
        else $error("pending event not emitted");
    a_evt_masked: assert property (@(posedge mclk_i) disable iff (rst_i)
        ((rise & ~evt_on_sel_i & ~pend_on_ff) != '0) |=> ((pend_on_ff & $past(rise & ~evt_on_sel_i & ~pend_on_ff)) == '0))
        else $error("unselected event queued");
endmodule

// ==== design/aac_pkg.sv ====
// Purpose: shared constants and types of the alarm annunciator control
// Assumes: one clock, synchronous active-high reset
// Notes: alarm grid is row-major, AAC_COLS boxes per row
package aac_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int AAC_NUM_ALARMS = 128;
    localparam int AAC_COLS = 8;
    localparam int AAC_IDX_W = 7;
    localparam int AAC_EVT_W = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [AAC_IDX_W-1:0] AAC_SEL_RST = 7'h00;
    localparam logic AAC_BUZZ_RST = 1'b0;
    localparam logic AAC_ZOOM_RST = 1'b0;

    // ****************************************
    // alarm states
    // ****************************************
    typedef enum logic [1:0] {
        AAC_INACTIVE,
        AAC_ACTIVE,
        AAC_ACT_ACK,
        AAC_INACT_UNACK
    } aac_state_t;
endpackage

// ==== design/aac_alarm_cell.sv ====
// Purpose: state of one alarm, with edge detection of its source
// Assumes: src_i already includes any latching
// Notes: rise_o and fall_o are combinational one-cycle pulses
module aac_alarm_cell
    import aac_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // control
    input wire logic src_i,
    input wire logic clear_i,
    input wire logic clr_act_en_i,
    // status
    output aac_state_t state_o,
    output logic rise_o,
    output logic fall_o
);
    aac_state_t state_ff;
    aac_state_t nxt_state;
    logic src_q_ff;

    assign rise_o = src_i & ~src_q_ff;
    assign fall_o = ~src_i & src_q_ff;
    assign state_o = state_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            AAC_INACTIVE: begin
                if (src_i) nxt_state = AAC_ACTIVE;
            end
            AAC_ACTIVE: begin
                if (!src_i) nxt_state = AAC_INACT_UNACK;
                else if (clear_i && clr_act_en_i) nxt_state = AAC_ACT_ACK;
            end
            AAC_ACT_ACK: begin
                if (!src_i) nxt_state = AAC_INACTIVE;
            end
            AAC_INACT_UNACK: begin
                // a fresh activation outranks a clear in the same cycle
                if (src_i) nxt_state = AAC_ACTIVE;
                else if (clear_i) nxt_state = AAC_INACTIVE;
            end
            default: nxt_state = AAC_INACTIVE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_ff <= AAC_INACTIVE;
            src_q_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            src_q_ff <= src_i;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_clear_ignored_active: assert property (
        state_ff == AAC_ACTIVE && src_i && !clr_act_en_i |=> state_ff == AAC_ACTIVE)
        else $error("clear taken while source active");
    a_unack_holds: assert property (
        state_ff == AAC_INACT_UNACK && !src_i && !clear_i |=> state_ff == AAC_INACT_UNACK)
        else $error("unacknowledged alarm left without clear");
    a_ack_returns_idle: assert property (
        state_ff == AAC_ACT_ACK && !src_i |=> state_ff == AAC_INACTIVE)
        else $error("acknowledged alarm did not return to inactive");
    a_clear_all_idle: assert property (
        state_ff == AAC_INACT_UNACK && clear_i && !src_i |=> state_ff == AAC_INACTIVE)
        else $error("clear did not reach inactive");
endmodule

// ==== design/aac_evt_pick.sv ====
// Purpose: pick the lowest pending event request
// Assumes: requests are held until granted
// Notes: purely combinational, fixed priority
module aac_evt_pick #(
    parameter int W = 256,
    parameter int IW = 8
) (
    // requests
    input wire logic [W-1:0] req_i,
    // choice
    output logic valid_o,
    output logic [IW-1:0] idx_o
);
    always_comb begin
        valid_o = 1'b0;
        idx_o = '0;
        // scan downward so the lowest index wins
        for (int k = W - 1; k >= 0; k--) begin
            if (req_i[k]) begin
                valid_o = 1'b1;
                idx_o = IW'(k);
            end
        end
    end
endmodule

// ==== verification/aac_panel_model.sv ====
// Purpose: front-panel keys and relay seen from outside the alarm unit
// Assumes: keys change one time unit after a rising clock edge
// Notes: key order is up, down, left, right, back, clear button, mute
module aac_panel_model (
    // clock
    input wire logic mclk_i,
    // keys and buttons
    output logic [6:0] key_o,
    // relay
    input wire logic buzzer_i,
    output logic relay_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial key_o = 7'h00;

    // relay contact just follows the buzzer drive
    assign relay_o = buzzer_i;

    // momentary press and release; a held key would hide later presses
    task automatic press(input int k);
        key_o[k] = 1'b1;
        @(posedge mclk_i);
        #1;
        key_o[k] = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: self-checking bench of the alarm annunciator control
// Assumes: inputs driven 1 ns after the rising clock edge
// Notes: scenarios run in order and share alarm state
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import aac_pkg::*;

    logic mclk_i;
    logic rst_i;
    logic [127:0] src;
    logic [127:0] latch_en;
    logic [127:0] on_sel;
    logic [127:0] off_sel;
    logic clr_act_en;
    logic zoom_en;
    logic clear_all;
    logic [6:0] key;
    logic [255:0] state;
    logic buzzer, relay, zoom, evt_valid, evt_on;
    logic [6:0] sel, evt_idx;
    int n_mismatch = 0;
    int n_checks = 0;

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    aac_panel_model panel (.mclk_i(mclk_i), .key_o(key), .buzzer_i(buzzer), .relay_o(relay));

    aac_top dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .src_i(src), .latch_en_i(latch_en),
        .evt_on_sel_i(on_sel), .evt_off_sel_i(off_sel), .clr_act_en_i(clr_act_en),
        .zoom_en_i(zoom_en), .key_up_i(key[0]), .key_down_i(key[1]), .key_left_i(key[2]),
        .key_right_i(key[3]), .key_back_i(key[4]), .fbtn_clear_i(key[5]),
        .clear_all_i(clear_all), .buzz_mute_i(key[6]), .state_o(state), .buzzer_o(buzzer),
        .zoom_o(zoom), .sel_o(sel), .evt_valid_o(evt_valid), .evt_idx_o(evt_idx),
        .evt_on_o(evt_on)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] st(input int i);
        return {6'h00, state[2*i +: 2]};
    endfunction

    task automatic wait_evt(input int idx, input logic on);
        int n;
        n = 0;
        while (evt_valid !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chk({7'h00, evt_valid}, 8'h01, "event missing");
        chk({1'h0, evt_idx}, idx[7:0], "event index");
        chk({7'h00, evt_on}, {7'h00, on}, "event kind");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_alarm();
        src[5] = 1'b1;
        tick();
        chk(st(5), AAC_ACTIVE, "alarm 5 active");
        chk({7'h00, buzzer}, 8'h01, "buzzer on rise");
        tick();
        wait_evt(5, 1'b1);
        tick();
        chk({7'h00, evt_valid}, 8'h00, "single event pulse");
        src[5] = 1'b0;
        tick();
        chk(st(5), AAC_INACT_UNACK, "dropped unacked");
        wait_evt(5, 1'b0);
        panel.press(5);
        chk(st(5), AAC_INACTIVE, "cleared by button");
        chk(st(6), AAC_INACTIVE, "neighbour untouched");
        $display("done t_alarm");
    endtask

    task automatic t_clear();
        src[9] = 1'b1;
        src[10] = 1'b1;
        tick();
        src[10] = 1'b0;
        tick();
        clear_all = 1'b1;
        tick();
        clear_all = 1'b0;
        chk(st(9), AAC_ACTIVE, "active ignores clear");
        chk(st(10), AAC_INACTIVE, "clear all clears");
        clr_act_en = 1'b1;
        clear_all = 1'b1;
        tick();
        clear_all = 1'b0;
        chk(st(9), AAC_ACT_ACK, "cleared while active");
        src[9] = 1'b0;
        tick();
        chk(st(9), AAC_INACTIVE, "ack drops to inactive");
        $display("done t_clear");
    endtask

    task automatic t_buzz();
        panel.press(6);
        chk({7'h00, buzzer}, 8'h00, "mute silences");
        repeat (3) tick();
        chk({7'h00, relay}, 8'h00, "stays muted");
        src[20] = 1'b1;
        tick();
        chk({7'h00, buzzer}, 8'h01, "new alarm resounds");
        panel.press(4);
        chk({7'h00, buzzer}, 8'h00, "back silences");
        $display("done t_buzz");
    endtask

    task automatic t_latch();
        latch_en[3] = 1'b1;
        src[3] = 1'b1;
        tick();
        src[3] = 1'b0;
        repeat (3) tick();
        chk(st(3), AAC_ACTIVE, "latched holds");
        panel.press(4);
        chk(st(3), AAC_INACT_UNACK, "back frees latch");
        latch_en[3] = 1'b0;
        $display("done t_latch");
    endtask

    task automatic t_mask();
        repeat (8) tick();
        on_sel[30] = 1'b0;
        src[30] = 1'b1;
        repeat (4) begin
            tick();
            chk({7'h00, evt_valid}, 8'h00, "masked on event");
        end
        src[30] = 1'b0;
        tick();
        wait_evt(30, 1'b0);
        // on-only mask: the rise is logged, the fall must be dropped
        off_sel[31] = 1'b0;
        src[31] = 1'b1;
        tick();
        tick();
        wait_evt(31, 1'b1);
        src[31] = 1'b0;
        repeat (4) begin
            tick();
            chk({7'h00, evt_valid}, 8'h00, "masked off event");
        end
        $display("done t_mask");
    endtask

    task automatic t_zoom();
        int keys[6] = '{2, 3, 1, 1, 0, 2};
        int exps[6] = '{0, 1, 9, 17, 9, 8};
        panel.press(0);
        chk({7'h00, zoom}, 8'h00, "no zoom when off");
        zoom_en = 1'b1;
        panel.press(0);
        chk({7'h00, zoom}, 8'h01, "zoom entered");
        chk({1'h0, sel}, 8'h00, "selection kept");
        for (int i = 0; i < 6; i++) begin
            panel.press(keys[i]);
            chk({1'h0, sel}, exps[i][7:0], "move selection");
        end
        panel.press(4);
        chk({7'h00, zoom}, 8'h00, "back leaves zoom");
        chk({1'h0, sel}, 8'h08, "selection after exit");
        $display("done t_zoom");
    endtask

    initial begin
        rst_i = 1'b1;
        src = '0;
        latch_en = '0;
        on_sel = '1;
        off_sel = '1;
        clr_act_en = 1'b0;
        zoom_en = 1'b0;
        clear_all = 1'b0;
        repeat (4) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        chk({7'h00, buzzer}, {7'h00, AAC_BUZZ_RST}, "buzzer reset");
        chk({7'h00, zoom}, {7'h00, AAC_ZOOM_RST}, "zoom reset");
        t_alarm();
        t_clear();
        t_buzz();
        t_latch();
        t_mask();
        t_zoom();
        test_done();
    end

    initial begin
        #200000;
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule
